// ---- sbc_dec_pkg.sv ----
// Constants and operation codes for the subtract and decrement-skip unit
`default_nettype none
package sub_dec_pkg;
    localparam int DATA_W = 8;
    localparam int NIB_W = 4;
    localparam int FLAG_W = 6;
    // Bit positions inside the status vector
    localparam int FLG_CARRY = 0;
    localparam int FLG_AUX = 1;
    localparam int FLG_ZERO = 2;
    localparam int FLG_OVF = 3;
    localparam int FLG_SCMP = 4;
    localparam int FLG_CZERO = 5;
    localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
    localparam logic [FLAG_W-1:0] FLAGS_RST = 6'h00;
    localparam logic [DATA_W-1:0] DEC_STEP = 8'h01;
    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
    localparam logic [1:0] RST_SYNC_RST = 2'h0;

    typedef enum logic [1:0] {
        sub_with_borrow_acc,
        sub_with_borrow_to_mem,
        dec_skip_zero_mem,
        dec_skip_zero_to_acc
    } op_t;
endpackage : sub_dec_pkg
`default_nettype wire

// ---- sbc_dec_unit.sv ----
// Subtract-with-borrow and decrement-skip-if-zero execution unit
`default_nettype none
module sub_dec_unit
    import sub_dec_pkg::*;
(
    input wire logic clk, // 50 MHz core clock
    input wire logic reset_n, // Async reset, active low
    input wire logic op_valid, // Instruction present
    output logic op_ready, // Unit can take an instruction
    input wire op_t op_sel, // Which operation
    input wire logic [DATA_W-1:0] operand, // Immediate or memory byte
    input wire logic acc_wr_en, // External accumulator load
    input wire logic [DATA_W-1:0] acc_wr_data, // Accumulator load value
    input wire logic flags_wr_en, // External status load
    input wire logic [FLAG_W-1:0] flags_wr_data, // Status load value
    output logic [DATA_W-1:0] acc, // Accumulator
    output logic [FLAG_W-1:0] flags, // Status flags
    output logic mem_wr_en, // Write result to addressed byte
    output logic [DATA_W-1:0] mem_wr_data, // Byte to write
    output logic skip_next // Dummy cycle, next instruction dropped
);
    logic [1:0] rst_sync_ff;
    logic rst_n;
    logic [DATA_W-1:0] acc_ff;
    logic [FLAG_W-1:0] flags_ff;
    logic mem_wr_en_ff;
    logic [DATA_W-1:0] mem_wr_data_ff;
    logic skip_ff;
    logic fire;
    logic is_sub;
    logic is_dec;
    logic borrow_in;
    logic [DATA_W:0] diff;
    logic [NIB_W:0] nib_diff;
    logic [DATA_W-1:0] sub_res;
    logic [DATA_W-1:0] dec_res;
    logic ovf;
    logic [FLAG_W-1:0] sub_flags;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync_ff <= RST_SYNC_RST;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    // Dummy cycle blocks the fetched instruction behind a skip
    assign op_ready = rst_n && !skip_ff;
    assign fire = op_valid && op_ready;
    assign is_sub = (op_sel == sub_with_borrow_acc)
                 || (op_sel == sub_with_borrow_to_mem);
    assign is_dec = !is_sub;

    // Carry set means no borrow, so borrow in is its complement
    assign borrow_in = !flags_ff[FLG_CARRY];
    assign diff = {1'b0, acc_ff} - {1'b0, operand}
                - {{DATA_W{1'b0}}, borrow_in};
    assign nib_diff = {1'b0, acc_ff[NIB_W-1:0]}
                    - {1'b0, operand[NIB_W-1:0]}
                    - {{NIB_W{1'b0}}, borrow_in};
    assign sub_res = diff[DATA_W-1:0];
    assign ovf = (acc_ff[DATA_W-1] ^ operand[DATA_W-1])
              && (acc_ff[DATA_W-1] ^ sub_res[DATA_W-1]);
    assign dec_res = operand - DEC_STEP;

    always_comb begin
        sub_flags = flags_ff;
        sub_flags[FLG_CARRY] = !diff[DATA_W];
        sub_flags[FLG_AUX] = !nib_diff[NIB_W];
        sub_flags[FLG_ZERO] = (sub_res == ZERO_BYTE);
        sub_flags[FLG_OVF] = ovf;
        // Sign of the true result, immune to overflow
        sub_flags[FLG_SCMP] = sub_res[DATA_W-1] ^ ovf;
        sub_flags[FLG_CZERO] = (sub_res == ZERO_BYTE);
    end

    // External loads lose to an instruction in the same cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_ff <= ACC_RST;
        end else if (fire && op_sel == sub_with_borrow_acc) begin
            acc_ff <= sub_res;
        end else if (fire && op_sel == dec_skip_zero_to_acc) begin
            acc_ff <= dec_res;
        end else if (!fire && acc_wr_en) begin
            acc_ff <= acc_wr_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_ff <= FLAGS_RST;
        end else if (fire && is_sub) begin
            flags_ff <= sub_flags;
        end else if (!fire && flags_wr_en) begin
            flags_ff <= flags_wr_data;
        end
        // Decrement variants fall through: flags held
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_wr_en_ff <= 1'b0;
            mem_wr_data_ff <= ZERO_BYTE;
        end else if (fire && op_sel == sub_with_borrow_to_mem) begin
            mem_wr_en_ff <= 1'b1;
            mem_wr_data_ff <= sub_res;
        end else if (fire && op_sel == dec_skip_zero_mem) begin
            mem_wr_en_ff <= 1'b1;
            mem_wr_data_ff <= dec_res;
        end else begin
            mem_wr_en_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            skip_ff <= 1'b0;
        end else begin
            skip_ff <= fire && is_dec && (dec_res == ZERO_BYTE);
        end
    end

    assign acc = acc_ff;
    assign flags = flags_ff;
    assign mem_wr_en = mem_wr_en_ff;
    assign mem_wr_data = mem_wr_data_ff;
    assign skip_next = skip_ff;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_sub_acc;
        fire && op_sel == sub_with_borrow_acc;
    endsequence
    sequence s_dec_hit;
        fire && is_dec && operand == DEC_STEP;
    endsequence
    sequence s_dummy;
        skip_ff && !op_ready ##1 !skip_ff;
    endsequence

    property p_sub_acc;
        s_sub_acc |=> acc_ff == 8'($past(acc_ff) - $past(operand)
            - {7'h00, !$past(flags_ff[FLG_CARRY])});
    endproperty
    a_sub_acc: assert property (p_sub_acc)
        else $error("accumulator subtract result wrong");

    property p_carry;
        fire && is_sub |=> flags_ff[FLG_CARRY] ==
            ({1'b0, $past(acc_ff)} >= {1'b0, $past(operand)}
            + {8'h00, !$past(flags_ff[FLG_CARRY])});
    endproperty
    a_carry: assert property (p_carry)
        else $error("carry polarity wrong after subtract");

    property p_zero;
        s_sub_acc |=> flags_ff[FLG_ZERO] == (acc_ff == ZERO_BYTE)
            && flags_ff[FLG_CZERO] == flags_ff[FLG_ZERO];
    endproperty
    a_zero: assert property (p_zero)
        else $error("zero flags disagree with result");

    property p_sub_mem;
        fire && op_sel == sub_with_borrow_to_mem |=> mem_wr_en_ff
            && acc_ff == $past(acc_ff) && mem_wr_data_ff ==
            8'($past(acc_ff) - $past(operand)
            - {7'h00, !$past(flags_ff[FLG_CARRY])});
    endproperty
    a_sub_mem: assert property (p_sub_mem)
        else $error("memory subtract not written to memory");

    property p_dec_mem;
        fire && op_sel == dec_skip_zero_mem |=> mem_wr_en_ff
            && mem_wr_data_ff == 8'($past(operand) - 8'h01);
    endproperty
    a_dec_mem: assert property (p_dec_mem)
        else $error("decrement not written back");

    property p_skip;
        s_dec_hit |=> s_dummy;
    endproperty
    a_skip: assert property (p_skip)
        else $error("zero decrement did not give one dummy cycle");

    property p_no_skip;
        fire && is_dec && operand != DEC_STEP |=> !skip_ff && op_ready;
    endproperty
    a_no_skip: assert property (p_no_skip)
        else $error("nonzero decrement skipped");

    property p_dec_acc;
        fire && op_sel == dec_skip_zero_to_acc |=> !mem_wr_en_ff
            && acc_ff == 8'($past(operand) - 8'h01);
    endproperty
    a_dec_acc: assert property (p_dec_acc)
        else $error("accumulator decrement wrong or memory touched");

    property p_dec_flags;
        fire && is_dec |=> $stable(flags_ff);
    endproperty
    a_dec_flags: assert property (p_dec_flags)
        else $error("decrement changed status flags");

    property p_sub_quiet;
        s_sub_acc |=> !mem_wr_en_ff && !skip_ff;
    endproperty
    a_sub_quiet: assert property (p_sub_quiet)
        else $error("accumulator subtract touched memory or skipped");
endmodule : sub_dec_unit
`default_nettype wire

// ---- sbc_dec_unit_end.sv ----
// Intentionally empty companion file
`default_nettype none
`default_nettype wire

// ---- test_subtract_borrow_and_decrement_skip.sv ----
// Self-checking bench for the subtract and decrement-skip unit
`default_nettype none
module test_subtract_borrow_and_decrement_skip
    import sub_dec_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, reset_n, op_valid, acc_wr_en, flags_wr_en;
    logic op_ready, mem_wr_en, skip_next;
    op_t op_sel;
    logic [DATA_W-1:0] operand, acc_wr_data, acc, mem_wr_data;
    logic [FLAG_W-1:0] flags_wr_data, flags;
    int n_mismatch = 0;
    int comparisons = 0;
    int cycles = 0;

    sub_dec_unit DUT (.clk(clk), .reset_n(reset_n), .op_valid(op_valid),
        .op_ready(op_ready), .op_sel(op_sel), .operand(operand),
        .acc_wr_en(acc_wr_en), .acc_wr_data(acc_wr_data),
        .flags_wr_en(flags_wr_en), .flags_wr_data(flags_wr_data),
        .acc(acc), .flags(flags), .mem_wr_en(mem_wr_en),
        .mem_wr_data(mem_wr_data), .skip_next(skip_next));

    task automatic finish_test();
        $display("mismatches %0d of %0d comparisons", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input string what, input logic [7:0] seen,
                       input logic [7:0] expd);
        comparisons++;
        if (seen !== expd) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, expd, seen);
        end
    endtask : chk

    // Flag vector a borrow-subtract should leave behind
    function automatic logic [7:0] sub_flags(logic [7:0] a, logic [7:0] b,
                                             logic cin);
        logic [8:0] r;
        logic [4:0] n;
        logic ov;
        r = {1'h0, a} - {1'h0, b} - {8'h00, !cin};
        n = {1'h0, a[3:0]} - {1'h0, b[3:0]} - {4'h0, !cin};
        ov = (a[7] != b[7]) && (r[7] != a[7]);
        sub_flags = 8'h00;
        sub_flags[FLG_CARRY] = !r[8];
        sub_flags[FLG_AUX] = !n[4];
        sub_flags[FLG_ZERO] = (r[7:0] == 8'h00);
        sub_flags[FLG_OVF] = ov;
        sub_flags[FLG_SCMP] = r[7] ^ ov;
        sub_flags[FLG_CZERO] = (r[7:0] == 8'h00);
    endfunction : sub_flags

    task automatic preset(input logic [7:0] a, input logic [5:0] f);
        @(posedge clk);
        #1;
        acc_wr_en = 1'h1;
        acc_wr_data = a;
        flags_wr_en = 1'h1;
        flags_wr_data = f;
        @(posedge clk);
        #1;
        acc_wr_en = 1'h0;
        flags_wr_en = 1'h0;
    endtask : preset

    // Leaves us in the cycle where results of the fire edge are visible
    task automatic fire(input op_t op, input logic [7:0] v);
        @(posedge clk);
        #1;
        op_valid = 1'h1;
        op_sel = op;
        operand = v;
        chk("op_ready", {7'h00, op_ready}, 8'h01);
        @(posedge clk);
        #1;
        op_valid = 1'h0;
    endtask : fire

    task automatic t_sub_acc(input logic [7:0] a, input logic [7:0] b,
                             input logic cin);
        preset(a, {5'h15, cin});
        fire(sub_with_borrow_acc, b);
        chk("acc", acc, a - b - {7'h00, !cin});
        chk("flags", {2'h0, flags}, sub_flags(a, b, cin));
        chk("mem_wr_en", {7'h00, mem_wr_en}, 8'h00);
    endtask : t_sub_acc

    task automatic t_sub_mem();
        preset(8'h20, 6'h00);
        fire(sub_with_borrow_to_mem, 8'h30);
        chk("mem_wr_en", {7'h00, mem_wr_en}, 8'h01);
        chk("mem_wr_data", mem_wr_data, 8'hEF);
        chk("acc", acc, 8'h20);
        chk("flags", {2'h0, flags}, sub_flags(8'h20, 8'h30, 1'h0));
    endtask : t_sub_mem

    task automatic t_dec(input op_t op, input logic [7:0] v);
        logic [7:0] r;
        logic to_mem;
        r = v - 8'h01;
        to_mem = (op == dec_skip_zero_mem);
        preset(8'h5A, 6'h2B);
        fire(op, v);
        chk("mem_wr_en", {7'h00, mem_wr_en}, {7'h00, to_mem});
        if (to_mem) chk("mem_wr_data", mem_wr_data, r);
        chk("acc", acc, to_mem ? 8'h5A : r);
        chk("flags", {2'h0, flags}, 8'h2B);
        chk("skip_next", {7'h00, skip_next}, {7'h00, ~|r});
        chk("op_ready", {7'h00, op_ready}, {7'h00, r != 8'h00});
        @(posedge clk);
        #1;
        chk("skip_next late", {7'h00, skip_next}, 8'h00);
        chk("mem_wr_en late", {7'h00, mem_wr_en}, 8'h00);
        chk("op_ready late", {7'h00, op_ready}, 8'h01);
    endtask : t_dec

    // Instruction offered in the dummy cycle must be dropped
    task automatic t_skip_blocks();
        preset(8'h5A, 6'h2B);
        @(posedge clk);
        #1;
        op_valid = 1'h1;
        op_sel = dec_skip_zero_to_acc;
        operand = 8'h01;
        @(posedge clk);
        #1;
        op_sel = sub_with_borrow_acc;
        operand = 8'h10;
        chk("skip_next", {7'h00, skip_next}, 8'h01);
        chk("op_ready dummy", {7'h00, op_ready}, 8'h00);
        chk("acc", acc, 8'h00);
        @(posedge clk);
        #1;
        op_valid = 1'h0;
        chk("acc after dummy", acc, 8'h00);
        chk("flags after dummy", {2'h0, flags}, 8'h2B);
        chk("skip_next once", {7'h00, skip_next}, 8'h00);
    endtask : t_skip_blocks

    initial begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end

    // Whole run needs about 60 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            n_mismatch++;
            finish_test();
        end
    end

    initial begin
        reset_n = 1'h0;
        op_valid = 1'h0;
        op_sel = sub_with_borrow_acc;
        operand = 8'h00;
        acc_wr_en = 1'h0;
        acc_wr_data = 8'h00;
        flags_wr_en = 1'h0;
        flags_wr_data = 6'h00;
        repeat (2) @(posedge clk);
        #1;
        chk("acc at reset", acc, ACC_RST);
        chk("flags at reset", {2'h0, flags}, {2'h0, FLAGS_RST});
        chk("mem_wr_en at reset", {7'h00, mem_wr_en}, 8'h00);
        chk("skip_next at reset", {7'h00, skip_next}, 8'h00);
        chk("op_ready at reset", {7'h00, op_ready}, 8'h00);
        reset_n = 1'h1;
        repeat (3) @(posedge clk);
        t_sub_acc(8'h05, 8'h03, 1'h1);
        t_sub_acc(8'h05, 8'h05, 1'h0);
        t_sub_acc(8'h80, 8'h01, 1'h1);
        t_sub_acc(8'h10, 8'h01, 1'h1);
        t_sub_acc(8'h03, 8'h03, 1'h1);
        t_sub_mem();
        t_dec(dec_skip_zero_mem, 8'h01);
        t_dec(dec_skip_zero_mem, 8'h00);
        t_dec(dec_skip_zero_mem, 8'h80);
        t_dec(dec_skip_zero_to_acc, 8'h01);
        t_dec(dec_skip_zero_to_acc, 8'h37);
        t_skip_blocks();
        finish_test();
    end
endmodule : test_subtract_borrow_and_decrement_skip
`default_nettype wire
